// [rtl/qsd_top.sv]
/*
  Quadrature step decoder: encoder contacts A/B to select, step clock, direction.
  Assumes A/B and the polarity pin are asynchronous; one 50 MHz clock.
*/
// Contract
// - Averaging filter on each encoder input
// - Filter rejects 3.0 ms bounce
// - Two-threshold hysteresis on filtered value
// - Stability timer gates debounced change
// - Up step: A change then B
// - Down step: B change then A
// - Direction high for up, low down
// - Single-input wiggles produce no step
// - Requests during pulse sequence discarded
// - Two steps per quadrature cycle
// - 20 ms reset hold, outputs released
// - Idle levels, then 50 ms hold
// - Select active low, idles high
// - Select low until 200 us after clock
`timescale 1ns/1ps
module qsd_top
  import qsd_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = RESET_HOLD_CYC,
  parameter int unsigned START_CYC = STARTUP_CYC,
  parameter int unsigned STAB_CYC  = STABLE_CYC,
  parameter int unsigned TICK_CYC  = FILT_TICK_CYC,
  parameter int unsigned LEAD_CYC  = SEL_LEAD_CYC,
  parameter int unsigned PULSE_CYC = CLK_PULSE_CYC,
  parameter int unsigned TAIL_CYC  = SEL_TAIL_CYC
) (
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic enc_a_in,
  input  wire logic enc_b_in,
  input  wire logic clk_invert_in,
  output logic      sel_n_out,
  output logic      sel_n_oe_out,
  output logic      step_clk_out,
  output logic      step_clk_oe_out,
  output logic      up_out,
  output logic      up_oe_out
);
  typedef struct packed {
    logic [1:0]       a_sy;
    logic [1:0]       b_sy;
    logic [1:0]       inv_sy;
    qsd_state_e       state;
    logic [CNT_W-1:0] cnt;
    logic             a_q;
    logic             b_q;
    logic [1:0]       last;
    logic             up;
    logic             sel_n;
    logic             clk_hi;
    logic             oe;
    logic             clk_out;
  } qsd_top_s;

  qsd_top_s st;
  qsd_top_s next_st;
  logic     a_deb;
  logic     b_deb;
  logic     deb_init;
  logic     a_chg;
  logic     b_chg;
  logic     busy_pair;
  logic [1:0] raw_sy;
  logic [1:0] deb_lvl;

  assign deb_init = (st.state == ST_HOLD);

  // Inputs enter through two flip-flops before any logic
  assign raw_sy = {st.b_sy[1], st.a_sy[1]};

  // One debouncer per encoder contact: index 0 is A, index 1 is B
  for (genvar i = 0; i < 2; i++) begin : g_deb
    qsd_debounce #(
      .STABLE (STAB_CYC),
      .TICK   (TICK_CYC)
    ) u_deb (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .raw_in      (raw_sy[i]),
      .init_in     (deb_init),
      .level_out   (deb_lvl[i])
    );
  end

  assign a_deb = deb_lvl[0];
  assign b_deb = deb_lvl[1];

  assign a_chg = (a_deb != st.a_q);
  assign b_chg = (b_deb != st.b_q);

  // An edge that would complete a pair of edges on both inputs
  assign busy_pair = (b_chg && st.last == 2'b01) || (a_chg && st.last == 2'b10);

  always_comb begin
    next_st        = st;
    next_st.a_sy   = {st.a_sy[0], enc_a_in};
    next_st.b_sy   = {st.b_sy[0], enc_b_in};
    next_st.inv_sy = {st.inv_sy[0], clk_invert_in};
    next_st.a_q    = a_deb;
    next_st.b_q    = b_deb;
    next_st.cnt    = st.cnt + 1'b1;
    // Edge history: 2'b01 = A last, 2'b10 = B last
    if (a_chg && st.state != ST_HOLD && st.state != ST_START)
      next_st.last = 2'b01;
    else if (b_chg && st.state != ST_HOLD && st.state != ST_START)
      next_st.last = 2'b10;
    case (st.state)
      ST_HOLD: begin
        if (st.cnt >= CNT_W'(HOLD_CYC - 1)) begin
          next_st.state = ST_START;
          next_st.cnt   = '0;
          next_st.oe    = 1'b1;
          next_st.sel_n = 1'b1;
          next_st.last  = 2'b00;
        end
      end
      ST_START: begin
        if (st.cnt >= CNT_W'(START_CYC - 1)) begin
          next_st.state = ST_IDLE;
          next_st.cnt   = '0;
        end
      end
      ST_IDLE: begin
        next_st.cnt = '0;
        // A pair of edges makes one step and is then used up,
        // so a full quadrature cycle gives two steps
        if (b_chg && st.last == 2'b01) begin
          next_st.up    = 1'b1;
          next_st.sel_n = 1'b0;
          next_st.state = ST_LEAD;
          next_st.last  = 2'b00;
        end else if (a_chg && st.last == 2'b10) begin
          next_st.up    = 1'b0;
          next_st.sel_n = 1'b0;
          next_st.state = ST_LEAD;
          next_st.last  = 2'b00;
        end
        // Repeat edges on the same input leave last unchanged: no step
      end
      ST_LEAD: begin
        // A step requested while busy is dropped, not queued
        if (busy_pair)
          next_st.last = 2'b00;
        if (st.cnt >= CNT_W'(LEAD_CYC - 1)) begin
          next_st.cnt    = '0;
          next_st.clk_hi = 1'b1;
          next_st.state  = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (busy_pair)
          next_st.last = 2'b00;
        if (st.clk_hi && st.cnt >= CNT_W'(PULSE_CYC - 1)) begin
          next_st.clk_hi = 1'b0;
          next_st.cnt    = '0;
        end else if (!st.clk_hi && st.cnt >= CNT_W'(TAIL_CYC - 1)) begin
          next_st.sel_n = 1'b1;
          next_st.state = ST_IDLE;
          next_st.cnt   = '0;
        end
      end
      default: begin
        next_st.state = ST_HOLD;
        next_st.cnt   = '0;
      end
    endcase
    next_st.clk_out = next_st.clk_hi ^ st.inv_sy[1];
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st       <= '0;
      st.state <= ST_HOLD;
      st.sel_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Pins float (oe low) during the reset hold
  assign sel_n_out       = st.sel_n;
  assign sel_n_oe_out    = st.oe;
  assign step_clk_out    = st.clk_out;
  assign step_clk_oe_out = st.oe;
  assign up_out          = st.up;
  assign up_oe_out       = st.oe;
endmodule

// [rtl/qsd_pkg.sv]
/*
  Constants and carrier types for the quadrature step decoder.
  Assumes a single 50 MHz core clock; times are converted to cycles here, except the bounce time, which becomes filter ticks.
*/
package qsd_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BOUNCE_US       = 3000;
  localparam int unsigned RESET_HOLD_MS   = 20;
  localparam int unsigned STARTUP_MS      = 50;
  localparam int unsigned SEL_TAIL_US     = 200;
  localparam int unsigned SEL_LEAD_US     = 10;
  localparam int unsigned CLK_PULSE_US    = 20;
  localparam int unsigned STABLE_US       = 1000;
  localparam int unsigned FILT_TICK_US    = 100;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam int unsigned RESET_HOLD_CYC  = RESET_HOLD_MS * 1000 * CYC_PER_US;
  localparam int unsigned STARTUP_CYC     = STARTUP_MS * 1000 * CYC_PER_US;
  localparam int unsigned SEL_TAIL_CYC    = SEL_TAIL_US * CYC_PER_US;
  localparam int unsigned SEL_LEAD_CYC    = SEL_LEAD_US * CYC_PER_US;
  localparam int unsigned CLK_PULSE_CYC   = CLK_PULSE_US * CYC_PER_US;
  localparam int unsigned STABLE_CYC      = STABLE_US * CYC_PER_US;
  localparam int unsigned FILT_TICK_CYC   = FILT_TICK_US * CYC_PER_US;
  // Filter window spans the worst bounce so noise averages out
  localparam int unsigned FILT_MAX        = BOUNCE_US / FILT_TICK_US;
  localparam int unsigned FILT_W          = 6;
  localparam logic [5:0]  FILT_HI         = 6'h16;
  localparam logic [5:0]  FILT_LO         = 6'h08;
  localparam int unsigned CNT_W           = 22;

  typedef enum logic [4:0] {
    ST_HOLD  = 5'h01,
    ST_START = 5'h02,
    ST_IDLE  = 5'h04,
    ST_LEAD  = 5'h08,
    ST_PULSE = 5'h10
  } qsd_state_e;

  typedef struct packed {
    logic sel_n;
    logic clk;
    logic up;
    logic oe;
  } qsd_out_s;
endpackage

// [rtl/qsd_debounce.sv]
/*
  One-input debouncer: averaging filter, hysteresis comparator, stability timer.
  Assumes the input is already synchronised to core_clk_in.
*/
`timescale 1ns/1ps
module qsd_debounce
  import qsd_pkg::*;
#(
  parameter int unsigned STABLE = STABLE_CYC,
  parameter int unsigned TICK   = FILT_TICK_CYC
) (
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic raw_in,
  input  wire logic init_in,
  output logic      level_out
);
  typedef struct packed {
    logic [CNT_W-1:0]  tick;
    logic [FILT_W-1:0] avg;
    logic              cmp;
    logic [CNT_W-1:0]  stab;
    logic              level;
  } qsd_deb_s;

  qsd_deb_s st;
  qsd_deb_s next_st;

  always_comb begin
    next_st = st;
    next_st.tick = st.tick + 1'b1;
    if (st.tick >= CNT_W'(TICK - 1)) begin
      next_st.tick = '0;
      // Up/down integrator approximates the mean level
      if (raw_in && st.avg < FILT_W'(FILT_MAX))
        next_st.avg = st.avg + 1'b1;
      else if (!raw_in && st.avg != '0)
        next_st.avg = st.avg - 1'b1;
    end
    if (st.avg >= FILT_HI)
      next_st.cmp = 1'b1;
    else if (st.avg <= FILT_LO)
      next_st.cmp = 1'b0;
    if (st.cmp == st.level)
      next_st.stab = '0;
    else if (st.stab >= CNT_W'(STABLE - 1)) begin
      next_st.stab  = '0;
      next_st.level = st.cmp;
    end else
      next_st.stab = st.stab + 1'b1;
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else if (init_in) begin
      st       <= '0;
      st.avg   <= raw_in ? FILT_W'(FILT_MAX) : '0;
      st.cmp   <= raw_in;
      st.level <= raw_in;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.level;
endmodule

// [tb/qsd_chk.sv]
/* Port timing checker for qsd_top.
   Assumes clk_invert_in stays steady while a step is shown. */
`timescale 1ns/1ps
module qsd_chk
  import qsd_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = 100,
  parameter int unsigned START_CYC = 100,
  parameter int unsigned LEAD_CYC  = SEL_LEAD_CYC,
  parameter int unsigned PULSE_CYC = CLK_PULSE_CYC,
  parameter int unsigned TAIL_CYC  = SEL_TAIL_CYC
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_invert_in,
  input wire logic sel_n_out,
  input wire logic sel_n_oe_out,
  input wire logic step_clk_out,
  input wire logic step_clk_oe_out,
  input wire logic up_out,
  input wire logic up_oe_out
);
  logic [31:0] cnt;
  logic [15:0] lowrun;
  logic [15:0] arun;
  wire  logic  act = !sel_n_out && (step_clk_out != clk_invert_in);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  always_ff @(posedge core_clk_in) begin
    cnt    <= !reset_n_in ? 32'h0 : cnt + {31'h0, cnt < 32'hffff};
    lowrun <= sel_n_out ? 16'h0 : lowrun + 16'h1;
    arun   <= act ? arun + 16'h1 : 16'h0;
  end
  oe_same_a: assert property (
    step_clk_oe_out == sel_n_oe_out && up_oe_out == sel_n_oe_out) else $error("oe differ");
  hold_tristate_a: assert property (
    cnt < HOLD_CYC - 2 |-> !sel_n_oe_out) else $error("oe early");
  start_quiet_a: assert property (
    cnt < HOLD_CYC + START_CYC - 2 |-> sel_n_out) else $error("select moved in startup");
  sel_lead_a: assert property (
    $fell(sel_n_out) |-> !act [*8] ##[1:1000] act) else $error("no clock after select");
  clk_in_sel_a: assert property (
    step_clk_out != clk_invert_in && $past(clk_invert_in, 6) == clk_invert_in |-> !sel_n_out)
    else $error("pulse outside select");
  sel_tail_a: assert property (
    $rose(sel_n_out) |-> lowrun == LEAD_CYC + PULSE_CYC + TAIL_CYC) else $error("select length");
  pulse_len_a: assert property (
    $fell(act) |-> arun == PULSE_CYC) else $error("pulse length");
  up_stable_a: assert property (
    !sel_n_out && $past(!sel_n_out) |-> $stable(up_out)) else $error("direction moved in step");
endmodule
bind qsd_top qsd_chk #(.HOLD_CYC(HOLD_CYC), .START_CYC(START_CYC), .LEAD_CYC(LEAD_CYC), .PULSE_CYC(PULSE_CYC),
  .TAIL_CYC(TAIL_CYC)) chk (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .clk_invert_in(clk_invert_in), .sel_n_out(sel_n_out), .sel_n_oe_out(sel_n_oe_out),
  .step_clk_out(step_clk_out), .step_clk_oe_out(step_clk_oe_out), .up_out(up_out), .up_oe_out(up_oe_out));

// [tb/qsd_enc.sv]
/* Encoder contact model: each level change chatters before it settles.
   Assumes pulled-up contacts sampled by the core clock. */
`timescale 1ns/1ps
module qsd_enc (
  input  wire logic core_clk_in,
  input  wire logic want_a_in,
  input  wire logic want_b_in,
  output logic      enc_a_out,
  output logic      enc_b_out
);
  logic [10:0] bnc_a = 11'h0;
  logic [10:0] bnc_b = 11'h0;
  logic        set_a = 1'b0;
  logic        set_b = 1'b0;
  always_ff @(posedge core_clk_in) begin
    set_a <= want_a_in;
    set_b <= want_b_in;
    bnc_a <= (want_a_in != set_a) ? 11'h7ff : bnc_a - {10'h0, bnc_a != 11'h0};
    bnc_b <= (want_b_in != set_b) ? 11'h7ff : bnc_b - {10'h0, bnc_b != 11'h0};
  end
  // Chatter toggles every 64 cycles while the bounce count runs
  assign enc_a_out = set_a ^ (bnc_a != 11'h0 && bnc_a[6]);
  assign enc_b_out = set_b ^ (bnc_b != 11'h0 && bnc_b[6]);
endmodule

// [tb/tb.sv]
/* Self-checking bench for qsd_top with a bouncing encoder model.
   Assumes shortened hold, startup and stability counts. */
`timescale 1ns/1ps
module tb;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      wa = 1'b0;
  logic      wb = 1'b0;
  logic      inv = 1'b0;
  wire logic a, b, sel_n, sel_oe, sclk, sclk_oe, up, up_oe;
  int        failures = 0;
  int        num_checks = 0;
  logic      fell, dir;
  always #10 clk = ~clk;
  qsd_enc enc (.core_clk_in(clk), .want_a_in(wa), .want_b_in(wb), .enc_a_out(a), .enc_b_out(b));
  qsd_top #(.HOLD_CYC(100), .START_CYC(100), .STAB_CYC(20), .TICK_CYC(8), .LEAD_CYC(10), .PULSE_CYC(20),
    .TAIL_CYC(50)) dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .enc_a_in(a), .enc_b_in(b), .clk_invert_in(inv), .sel_n_out(sel_n), .sel_n_oe_out(sel_oe),
    .step_clk_out(sclk), .step_clk_oe_out(sclk_oe), .up_out(up), .up_oe_out(up_oe));
  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Moves the contacts, then waits for a step and its end
  task automatic move(input logic na, input logic nb, output logic f, output logic d);
    int n;
    @(negedge clk);
    wa = na;
    wb = nb;
    f = 1'b0;
    for (n = 0; n < 4000 && !f; n++) begin
      @(negedge clk);
      f = (sel_n === 1'b0);
    end
    d = up;
    for (n = 0; n < 2000 && sel_n !== 1'b1; n++)
      @(negedge clk);
  endtask
  task automatic test_reset();
    repeat (5) @(negedge clk);
    check(sel_oe, 1'b0);
    rst_n = 1'b1;
    repeat (50) @(negedge clk);
    check(sel_oe, 1'b0);
    repeat (70) @(negedge clk);
    check(sel_oe, 1'b1);
    check(sel_n, 1'b1);
    check(sclk, 1'b0);
  endtask
  task automatic test_up();
    move(1'b1, 1'b0, fell, dir);
    check(fell, 1'b0);
    move(1'b1, 1'b1, fell, dir);
    check(fell, 1'b1);
    check(dir, 1'b1);
  endtask
  task automatic test_cycle();
    move(1'b0, 1'b1, fell, dir);
    check(fell, 1'b0);
    move(1'b0, 1'b0, fell, dir);
    check(fell, 1'b1);
  endtask
  task automatic test_wiggle();
    move(1'b0, 1'b1, fell, dir);
    check(fell, 1'b0);
    move(1'b0, 1'b0, fell, dir);
    check(fell, 1'b0);
  endtask
  task automatic test_down();
    inv = 1'b1;
    repeat (10) @(negedge clk);
    check(sclk, 1'b1);
    move(1'b1, 1'b0, fell, dir);
    check(fell, 1'b1);
    check(dir, 1'b0);
    check(sclk, 1'b1);
  endtask
  initial begin
    test_reset();
    test_up();
    test_cycle();
    test_wiggle();
    test_down();
    give_verdict();
  end
  initial begin
    #2_000_000;
    failures++;
    give_verdict();
  end
endmodule
